// File: rtl/rst_init_pkg.sv
package rst_init_pkg;
  // ----------------------------------------
  // reset kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    RK_NONE,
    RK_POWER_ON,
    RK_LOW_VOLT,
    RK_WDT_NORMAL,
    RK_WDT_IDLE
  } reset_kind_e;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_ACCUMULATOR = 8'h04;
  localparam logic [7:0] OFF_PC_LOW = 8'h08;
  localparam logic [7:0] OFF_OPTION_MAP = 8'h0c;
  localparam logic [7:0] OFF_RESET_FLAG = 8'h10;
  localparam logic [7:0] OFF_SYSCLK = 8'h14;
  localparam logic [7:0] OFF_FAST_OSC = 8'h18;
  localparam logic [7:0] OFF_PORT_LATCH = 8'h1c;
  localparam logic [7:0] OFF_PORT_DIR = 8'h20;
  localparam logic [7:0] OFF_PORT_PULL = 8'h24;
  localparam logic [7:0] OFF_PORT_WAKE = 8'h28;
  localparam logic [7:0] OFF_SOFT_KEY = 8'h2c;
  localparam logic [7:0] OFF_LV_SELECT = 8'h30;
  localparam logic [7:0] OFF_WDT_CTRL = 8'h34;
  localparam logic [7:0] OFF_INT_CTRL0 = 8'h38;
  localparam logic [7:0] OFF_SYNC_CTRL0 = 8'h3c;
  localparam logic [7:0] OFF_SER_CTRL1 = 8'h40;
  localparam logic [7:0] OFF_ASYNC_STATUS = 8'h44;
  localparam logic [7:0] OFF_SER_SELECT = 8'h48;
  localparam logic [7:0] OFF_RESET_EVENT = 8'h4c;
  localparam logic [7:0] OFF_STACK_PTR = 8'h50;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RV_PORT_LATCH = 8'hff;
  localparam logic [7:0] RV_PORT_DIR = 8'hff;
  localparam logic [7:0] RV_ZERO = 8'h00;
  localparam logic [7:0] RV_SAFE_KEY = 8'h55;
  localparam logic [7:0] RV_WDT_CTRL = 8'h53;
  localparam logic [7:0] RV_SYSCLK = 8'h00;
  localparam logic [7:0] SYSCLK_MASK = 8'hef;
  localparam logic [3:0] RV_FAST_OSC = 4'h1;
  localparam logic [7:0] RV_SYNC_CTRL1 = 8'h81;
  localparam logic [7:0] RV_ASYNC_CTRL1 = 8'h00;
  localparam logic [7:0] RV_SYNC_CTRL0 = 8'he0;
  localparam logic [7:0] RV_ASYNC_STATUS = 8'h0b;
  localparam logic [7:0] INT_CTRL0_MASK = 8'h7f;
  localparam logic [3:0] RV_RESET_FLAG = 4'h0;
  localparam logic [7:0] STATUS_CLEAR_MASK = 8'hcf;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int STATUS_TIMEOUT_BIT = 5;
  localparam int STATUS_POWERDOWN_BIT = 4;
  localparam int RFLAG_LOW_VOLT_BIT = 2;
  localparam int EVT_POWER_ON_BIT = 0;
  localparam int EVT_LOW_VOLT_BIT = 1;
  localparam int EVT_WDT_BIT = 2;
  localparam int EVT_IDLE_BIT = 3;
  localparam int EVT_PULSE_BIT = 4;

  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
endpackage : rst_init_pkg

// File: rtl/reset_kind_decode.sv
`timescale 1ns/100ps
`default_nettype none
// picks one reset kind from concurrent requests; power-on wins
module reset_kind_decode (
  input wire logic power_on_req, // power-on request
  input wire logic low_volt_req, // low-voltage reset request
  input wire logic wdt_req, // watchdog time-out request
  input wire logic idle_mode, // core in idle or sleep
  output rst_init_pkg::reset_kind_e kind // chosen kind
);
  always_comb begin
    if (power_on_req) begin
      kind = rst_init_pkg::RK_POWER_ON;
    end else if (low_volt_req) begin
      kind = rst_init_pkg::RK_LOW_VOLT;
    end else if (wdt_req) begin
      kind = idle_mode ? rst_init_pkg::RK_WDT_IDLE : rst_init_pkg::RK_WDT_NORMAL;
    end else begin
      kind = rst_init_pkg::RK_NONE;
    end
  end
endmodule // reset_kind_decode
`default_nettype wire

// File: rtl/reset_state_init.sv
`timescale 1ns/100ps
`default_nettype none
module reset_state_init (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic power_on_req, // power-on reset event
  input wire logic low_volt_req, // low-voltage reset event
  input wire logic wdt_req, // watchdog time-out event
  input wire logic idle_mode, // core in idle or sleep
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic [1:0] avs_response, // 00 ok, 10 slave error
  output logic init_pulse, // one-cycle init apply
  output logic [7:0] pc_low_byte, // program counter low
  output logic [2:0] stack_ptr, // return stack pointer
  output logic interrupts_off, // all interrupt sources disabled
  output logic timers_off, // timer modules off
  output logic wdt_clear, // watchdog and time bases clear
  output logic [7:0] port_a_direction, // 1 = input
  output logic [7:0] port_a_latch // output data latch
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] accumulator;
    logic [7:0] pc_low_byte;
    logic [7:0] option_map_control;
    logic [3:0] reset_flag_register;
    logic [7:0] sysclk_control;
    logic [3:0] fast_internal_osc_control;
    logic [7:0] port_a_latch;
    logic [7:0] port_a_direction;
    logic [7:0] port_a_pullhigh;
    logic [7:0] port_a_wakeup;
    logic [7:0] soft_reset_key;
    logic [7:0] low_voltage_select;
    logic [7:0] watchdog_control;
    logic [7:0] interrupt_control0;
    logic [7:0] sync_serial0_control0;
    logic [7:0] serial_ctrl1;
    logic [7:0] async0_status;
    logic serial0_interface_select;
    logic [2:0] stack_ptr;
    logic [4:0] last_event;
    logic interrupts_off;
    logic timers_off;
    logic wdt_clear;
    logic init_pulse;
    logic ack;
    logic [31:0] readdata;
    logic err;
  } state_s;

  state_s cur;
  state_s nxt;
  rst_init_pkg::reset_kind_e kind;

  reset_kind_decode u_decode (
    .power_on_req(power_on_req),
    .low_volt_req(low_volt_req),
    .wdt_req(wdt_req),
    .idle_mode(idle_mode),
    .kind(kind)
  );

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] val, input logic en);
    merge_byte = en ? val : old;
  endfunction

  wire logic req = avs_read | avs_write;
  // a write lands only on the completing edge, where waitrequest is low
  wire logic wr_lane = avs_write & avs_byteenable[0] & cur.ack;
  wire logic power_on = (kind == rst_init_pkg::RK_POWER_ON);
  wire logic wdt_norm = (kind == rst_init_pkg::RK_WDT_NORMAL);
  wire logic wdt_idle = (kind == rst_init_pkg::RK_WDT_IDLE);
  wire logic full_init = power_on | wdt_norm;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt = cur;
    nxt.init_pulse = 1'b0;
    nxt.wdt_clear = 1'b0;
    nxt.ack = 1'b0;
    nxt.err = 1'b0;
    // read data captured on the first edge, acknowledged on the next
    if (req) begin
      nxt.ack = !cur.ack;
      nxt.readdata = 32'h0000_0000;
      case (avs_address)
        rst_init_pkg::OFF_STATUS: begin
          nxt.readdata[7:0] = cur.status;
          if (wr_lane) nxt.status = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_ACCUMULATOR: begin
          nxt.readdata[7:0] = cur.accumulator;
          if (wr_lane) nxt.accumulator = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_PC_LOW: begin
          nxt.readdata[7:0] = cur.pc_low_byte;
          if (wr_lane) nxt.pc_low_byte = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_OPTION_MAP: begin
          nxt.readdata[7:0] = cur.option_map_control;
          if (wr_lane) nxt.option_map_control = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_RESET_FLAG: begin
          nxt.readdata[3:0] = cur.reset_flag_register;
          if (wr_lane) nxt.reset_flag_register = avs_writedata[3:0];
        end
        rst_init_pkg::OFF_SYSCLK: begin
          nxt.readdata[7:0] = cur.sysclk_control;
          if (wr_lane) nxt.sysclk_control = avs_writedata[7:0] & rst_init_pkg::SYSCLK_MASK;
        end
        rst_init_pkg::OFF_FAST_OSC: begin
          nxt.readdata[3:0] = cur.fast_internal_osc_control;
          if (wr_lane) nxt.fast_internal_osc_control = avs_writedata[3:0];
        end
        rst_init_pkg::OFF_PORT_LATCH: begin
          nxt.readdata[7:0] = cur.port_a_latch;
          if (wr_lane) nxt.port_a_latch = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_PORT_DIR: begin
          nxt.readdata[7:0] = cur.port_a_direction;
          if (wr_lane) nxt.port_a_direction = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_PORT_PULL: begin
          nxt.readdata[7:0] = cur.port_a_pullhigh;
          if (wr_lane) nxt.port_a_pullhigh = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_PORT_WAKE: begin
          nxt.readdata[7:0] = cur.port_a_wakeup;
          if (wr_lane) nxt.port_a_wakeup = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_SOFT_KEY: begin
          nxt.readdata[7:0] = cur.soft_reset_key;
          if (wr_lane) nxt.soft_reset_key = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_LV_SELECT: begin
          nxt.readdata[7:0] = cur.low_voltage_select;
          if (wr_lane) nxt.low_voltage_select = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_WDT_CTRL: begin
          nxt.readdata[7:0] = cur.watchdog_control;
          if (wr_lane) nxt.watchdog_control = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_INT_CTRL0: begin
          nxt.readdata[7:0] = cur.interrupt_control0;
          if (wr_lane) begin
            nxt.interrupt_control0 = avs_writedata[7:0] & rst_init_pkg::INT_CTRL0_MASK;
            nxt.interrupts_off = 1'b0; // software re-enables interrupts
          end
        end
        rst_init_pkg::OFF_SYNC_CTRL0: begin
          nxt.readdata[7:0] = cur.sync_serial0_control0;
          if (wr_lane) begin
            nxt.sync_serial0_control0 = avs_writedata[7:0];
            nxt.timers_off = 1'b0;
          end
        end
        rst_init_pkg::OFF_SER_CTRL1: begin
          nxt.readdata[7:0] = cur.serial_ctrl1;
          if (wr_lane) nxt.serial_ctrl1 = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_ASYNC_STATUS: begin
          nxt.readdata[7:0] = cur.async0_status;
          if (wr_lane) nxt.async0_status = avs_writedata[7:0];
        end
        rst_init_pkg::OFF_SER_SELECT: begin
          nxt.readdata[0] = cur.serial0_interface_select;
          if (wr_lane) nxt.serial0_interface_select = avs_writedata[0];
        end
        rst_init_pkg::OFF_RESET_EVENT: begin
          nxt.readdata[4:0] = cur.last_event;
          if (wr_lane) nxt.last_event = cur.last_event & ~avs_writedata[4:0];
        end
        rst_init_pkg::OFF_STACK_PTR: begin
          nxt.readdata[2:0] = cur.stack_ptr;
        end
        default: begin
          nxt.err = 1'b1;
        end
      endcase
    end
    // ----------------------------------------
    // reset-kind loading; overrides a same-cycle write
    // ----------------------------------------
    if (kind != rst_init_pkg::RK_NONE) begin
      nxt.init_pulse = 1'b1;
      nxt.wdt_clear = 1'b1;
      nxt.pc_low_byte = rst_init_pkg::RV_ZERO;
      nxt.option_map_control = rst_init_pkg::RV_ZERO;
      nxt.stack_ptr = 3'(rst_init_pkg::STACK_DEPTH - 1);
      nxt.last_event[rst_init_pkg::EVT_PULSE_BIT] = 1'b1;
      if (wdt_idle) begin
        nxt.stack_ptr = '0;
      end
    end
    if (power_on) begin
      nxt.status = cur.status & rst_init_pkg::STATUS_CLEAR_MASK;
      nxt.reset_flag_register = rst_init_pkg::RV_RESET_FLAG;
      nxt.interrupts_off = 1'b1;
      nxt.timers_off = 1'b1;
      nxt.last_event[rst_init_pkg::EVT_POWER_ON_BIT] = 1'b1;
    end
    if (kind == rst_init_pkg::RK_LOW_VOLT) begin
      nxt.reset_flag_register[rst_init_pkg::RFLAG_LOW_VOLT_BIT] = 1'b1;
      nxt.last_event[rst_init_pkg::EVT_LOW_VOLT_BIT] = 1'b1;
    end
    if (wdt_norm | wdt_idle) begin
      nxt.status[rst_init_pkg::STATUS_TIMEOUT_BIT] = 1'b1;
      nxt.last_event[rst_init_pkg::EVT_WDT_BIT] = 1'b1;
    end
    if (wdt_idle) begin
      nxt.status[rst_init_pkg::STATUS_POWERDOWN_BIT] = 1'b1;
      nxt.last_event[rst_init_pkg::EVT_IDLE_BIT] = 1'b1;
    end
    // accumulator and reset flags untouched on watchdog kinds
    if (full_init) begin // idle watchdog keeps all these
      nxt.port_a_latch = rst_init_pkg::RV_PORT_LATCH;
      nxt.port_a_direction = rst_init_pkg::RV_PORT_DIR;
      nxt.port_a_pullhigh = rst_init_pkg::RV_ZERO;
      nxt.port_a_wakeup = rst_init_pkg::RV_ZERO;
      nxt.soft_reset_key = rst_init_pkg::RV_SAFE_KEY;
      nxt.low_voltage_select = rst_init_pkg::RV_SAFE_KEY;
      nxt.watchdog_control = rst_init_pkg::RV_WDT_CTRL;
      nxt.sysclk_control = rst_init_pkg::RV_SYSCLK;
      nxt.fast_internal_osc_control = rst_init_pkg::RV_FAST_OSC;
      nxt.interrupt_control0 = rst_init_pkg::RV_ZERO;
      nxt.sync_serial0_control0 = rst_init_pkg::RV_SYNC_CTRL0;
      nxt.async0_status = rst_init_pkg::RV_ASYNC_STATUS;
      // the shared location takes the default of the selected interface
      nxt.serial_ctrl1 = cur.serial0_interface_select ? rst_init_pkg::RV_ASYNC_CTRL1
                                                      : rst_init_pkg::RV_SYNC_CTRL1;
    end
    // whatever wrote them, bit 7 of interrupt control0 and bit 4 of clock control stay zero
    nxt.interrupt_control0 = merge_byte(nxt.interrupt_control0,
                                        nxt.interrupt_control0 & rst_init_pkg::INT_CTRL0_MASK, 1'b1);
    nxt.sysclk_control = nxt.sysclk_control & rst_init_pkg::SYSCLK_MASK;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // the bus reset stands for a power-on: accumulator has no defined value, zero chosen
      cur <= '0;
      cur.port_a_latch <= rst_init_pkg::RV_PORT_LATCH;
      cur.port_a_direction <= rst_init_pkg::RV_PORT_DIR;
      cur.soft_reset_key <= rst_init_pkg::RV_SAFE_KEY;
      cur.low_voltage_select <= rst_init_pkg::RV_SAFE_KEY;
      cur.watchdog_control <= rst_init_pkg::RV_WDT_CTRL;
      cur.fast_internal_osc_control <= rst_init_pkg::RV_FAST_OSC;
      cur.sync_serial0_control0 <= rst_init_pkg::RV_SYNC_CTRL0;
      cur.serial_ctrl1 <= rst_init_pkg::RV_SYNC_CTRL1;
      cur.async0_status <= rst_init_pkg::RV_ASYNC_STATUS;
      cur.stack_ptr <= 3'(rst_init_pkg::STACK_DEPTH - 1);
      cur.interrupts_off <= 1'b1;
      cur.timers_off <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  assign avs_waitrequest = req & ~cur.ack;
  assign avs_readdata = cur.readdata;
  assign avs_response = cur.err ? 2'b10 : 2'b00;
  assign init_pulse = cur.init_pulse;
  assign pc_low_byte = cur.pc_low_byte;
  assign stack_ptr = cur.stack_ptr;
  assign interrupts_off = cur.interrupts_off;
  assign timers_off = cur.timers_off;
  assign wdt_clear = cur.wdt_clear;
  assign port_a_direction = cur.port_a_direction;
  assign port_a_latch = cur.port_a_latch;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_flags_power_on: assert property (power_on |=> !cur.status[5] && !cur.status[4])
    else $error("power-on did not clear status flags");
  a_flags_wdt_idle: assert property (wdt_idle |=> cur.status[5] && cur.status[4])
    else $error("idle watchdog did not set both flags");
  a_flags_wdt_norm: assert property (wdt_norm |=> cur.status[5] && cur.status[4] == $past(cur.status[4]))
    else $error("normal watchdog flags wrong");
  a_flags_low_volt: assert property (kind == rst_init_pkg::RK_LOW_VOLT |=> cur.status[5:4] == $past(cur.status[5:4]))
    else $error("low-voltage reset changed flags");
  a_pc_cleared: assert property (kind != rst_init_pkg::RK_NONE |=> pc_low_byte == 8'h00 && cur.option_map_control == 8'h00)
    else $error("pc low or option map not cleared");
  a_int_off: assert property (power_on |=> interrupts_off && timers_off)
    else $error("interrupts or timers not off");
  a_ports_full: assert property (full_init |=> port_a_latch == 8'hff && port_a_direction == 8'hff && cur.port_a_pullhigh == 8'h00)
    else $error("port defaults wrong");
  a_ports_keep: assert property (wdt_idle |=> port_a_direction == $past(port_a_direction) && cur.port_a_wakeup == $past(cur.port_a_wakeup))
    else $error("idle watchdog changed ports");
  a_acc_keep: assert property (wdt_norm || wdt_idle |=> cur.accumulator == $past(cur.accumulator))
    else $error("accumulator changed by watchdog");
  a_key_default: assert property (full_init |=> cur.soft_reset_key == 8'h55 && cur.watchdog_control == 8'h53)
    else $error("key or watchdog control default wrong");
  a_sp_idle: assert property (wdt_idle |=> stack_ptr == 3'd0)
    else $error("idle watchdog stack pointer not zero");
  a_init_once: assert property (kind != rst_init_pkg::RK_NONE |=> init_pulse && wdt_clear)
    else $error("init pulse missing");
  a_unimpl_zero: assert property (!cur.interrupt_control0[7] && !cur.sysclk_control[4])
    else $error("unimplemented bit set");

  c_power_on: cover property (power_on);
  c_wdt_norm: cover property (wdt_norm);
  c_wdt_idle: cover property (wdt_idle);
  c_bus_read: cover property (avs_read && !avs_waitrequest);
endmodule // reset_state_init
`default_nettype wire

// File: tb/core_event_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------
// stand-in for the core raising reset events
// -----------------------------------------
module core_event_model (
  input wire logic core_clk, // system clock
  input wire logic fire, // send the events in ev_mask
  input wire logic [3:0] ev_mask, // idle, watchdog, low voltage, power on
  output logic power_on_req = 1'b0, // power-on event
  output logic low_volt_req = 1'b0, // low-voltage event
  output logic wdt_req = 1'b0, // watchdog time-out
  output logic idle_mode = 1'b0 // core halted
);
  // one cycle per request, so that each event is seen exactly once
  always_ff @(posedge core_clk) begin
    power_on_req <= fire & ev_mask[0];
    low_volt_req <= fire & ev_mask[1];
    wdt_req <= fire & ev_mask[2];
    idle_mode <= fire & ev_mask[3];
  end
endmodule // core_event_model
`default_nettype wire

// File: tb/test_mcu_reset_state_init.sv
`timescale 1ns/100ps
`default_nettype none
module test_mcu_reset_state_init;
  logic core_clk, reset_n, fire, avs_read, avs_write, avs_waitrequest, init_pulse;
  logic interrupts_off, timers_off, wdt_clear, power_on_req, low_volt_req, wdt_req, idle_mode;
  logic [3:0] ev_mask, avs_byteenable, rf;
  logic [7:0] avs_address, pc_low_byte, port_a_direction, port_a_latch;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] avs_response, rsp;
  logic [2:0] stack_ptr;
  int bad_count, total_checks;
  // acc, latch, dir, pull, wake, key, lv, wdt, int0, sync0, clk, osc, async, pc low, option map
  logic [7:0] offs [15] = '{8'h04, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h14,
    8'h18, 8'h44, 8'h08, 8'h0c};
  logic [7:0] dfl [15] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h55, 8'h55, 8'h53, 8'h00, 8'he0, 8'h00,
    8'h01, 8'h0b, 8'h00, 8'h00};
  // zero mask: left unwritten, so a kept value equals its default
  logic [7:0] msk [15] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h00,
    8'h00, 8'h00, 8'hff, 8'hff};
  logic [7:0] wv [15];
  core_event_model partner (.core_clk(core_clk), .fire(fire), .ev_mask(ev_mask), .power_on_req(power_on_req),
    .low_volt_req(low_volt_req), .wdt_req(wdt_req), .idle_mode(idle_mode));
  reset_state_init uut (.core_clk(core_clk), .reset_n(reset_n), .power_on_req(power_on_req),
    .low_volt_req(low_volt_req), .wdt_req(wdt_req), .idle_mode(idle_mode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .init_pulse(init_pulse), .pc_low_byte(pc_low_byte),
    .stack_ptr(stack_ptr), .interrupts_off(interrupts_off), .timers_off(timers_off), .wdt_clear(wdt_clear),
    .port_a_direction(port_a_direction), .port_a_latch(port_a_latch));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // request held until waitrequest is sampled low at a rising edge; data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic evt(input logic [3:0] m);
    @(posedge core_clk);
    fire <= 1'b1;
    ev_mask <= m;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(init_pulse, 1'b1, "init pulse");
    chk(wdt_clear, 1'b1, "watchdog clear");
    @(negedge core_clk);
    chk(init_pulse, 1'b0, "init pulse width");
  endtask
  // kind: 0 power-on, 1 normal watchdog, 2 idle watchdog
  function automatic logic [7:0] expect_val(int i, int kind);
    if (i >= 13) return 8'h00;
    // the accumulator has no defined reset value: every reset event keeps it
    if (kind == 2 || i == 0) return (msk[i] != 8'h00) ? (wv[i] & msk[i]) : dfl[i];
    return dfl[i];
  endfunction
  task automatic scramble();
    for (int i = 0; i < 15; i++) begin
      wv[i] = 8'($urandom);
      if (msk[i] != 8'h00) bus(1'b1, offs[i], {24'($urandom), wv[i]});
    end
  endtask
  task automatic sweep(input int kind, input logic [1:0] st, input logic [2:0] sp);
    for (int i = 0; i < 15; i++) begin
      bus(1'b0, offs[i], 32'h0);
      chk(q, {24'h0, expect_val(i, kind)}, "register");
      chk(rsp, 2'b00, "mapped response");
    end
    bus(1'b0, 8'h00, 32'h0);
    chk(q[5:4], st, "status flags");
    chk(stack_ptr, sp, "stack pointer");
    chk(pc_low_byte, 8'h00, "program counter");
    chk(port_a_latch, expect_val(1, kind), "latch pins");
    chk(port_a_direction, expect_val(2, kind), "direction pins");
  endtask
  initial begin
    reset_n = 1'b0;
    {fire, avs_read, avs_write, ev_mask, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'h39f9));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 15; i++) wv[i] = 8'h00;
    sweep(0, 2'b00, 3'd7);
    chk(interrupts_off, 1'b1, "interrupts off");
    chk(timers_off, 1'b1, "timers off");
    $display("test reset values done");
    scramble();
    chk(interrupts_off, 1'b0, "interrupts enabled");
    chk(timers_off, 1'b0, "timers enabled");
    evt(4'b0100);
    sweep(1, 2'b10, 3'd7);
    $display("test normal watchdog done");
    scramble();
    rf = 4'($urandom);
    bus(1'b1, 8'h10, {$urandom, 4'h0} | 32'(rf));
    evt(4'b1100);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'(rf), "reset flags idle");
    sweep(2, 2'b11, 3'd0);
    $display("test idle watchdog done");
    evt(4'b0010);
    bus(1'b0, 8'h10, 32'h0);
    chk(q[2], 1'b1, "low voltage flag");
    bus(1'b0, 8'h00, 32'h0);
    chk(q[5:4], 2'b11, "status after low voltage");
    bus(1'b0, 8'h2c, 32'h0);
    chk(q[7:0], wv[5], "key after low voltage");
    $display("test low voltage done");
    evt(4'b0101);
    sweep(0, 2'b00, 3'd7);
    chk(interrupts_off, 1'b1, "interrupts off again");
    chk(timers_off, 1'b1, "timers off again");
    $display("test power-on priority done");
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 8'h48, 32'(s));
      evt(4'b0100);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, (s == 1) ? 32'h00 : 32'h81, "serial control1");
    end
    $display("test serial mode done");
    bus(1'b0, 8'hfc, 32'h0);
    chk({rsp, q}, {2'b10, 32'h0}, "unmapped read");
    bus(1'b1, 8'hfc, $urandom);
    chk(rsp, 2'b10, "unmapped write");
    $display("test unmapped done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
endmodule // test_mcu_reset_state_init
`default_nettype wire
